// file: plcfe_consts.svh
`ifndef PLCFE_CONSTS_SVH
`define PLCFE_CONSTS_SVH

// register addresses on the serial link
`define PLCFE_ADDR_BLOCK_ENABLES_SECOND 6'h03
`define PLCFE_ADDR_FILTER_CALIBRATION_CONTROL 6'h04
`define PLCFE_ADDR_FAULT_FLAG_CONTROL 6'h05
`define PLCFE_ADDR_RESET_STATUS 6'h09

// reset values
`define PLCFE_RST_BLOCK_ENABLES_SECOND 8'h00
`define PLCFE_RST_FILTER_CALIBRATION_CONTROL 8'h00
`define PLCFE_RST_FAULT_FLAG_CONTROL 8'h01
`define PLCFE_RST_FLAGS 2'h0

// block_enables_second fields
`define PLCFE_BIT_ZERO_CROSS 0
`define PLCFE_BIT_REFERENCE_A 1
`define PLCFE_BIT_REFERENCE_B 2
`define PLCFE_BIT_AMP_OUTPUT 3
`define PLCFE_MASK_BLOCK_ENABLES_SECOND 8'h0F

// filter_calibration_control fields
`define PLCFE_BIT_TX_CAL 0
`define PLCFE_BIT_RX_CAL 1
`define PLCFE_BIT_TX_GAIN_CAL 2
`define PLCFE_BIT_BAND 3
`define PLCFE_BIT_TX_READY 6
`define PLCFE_BIT_RX_READY 7
`define PLCFE_MASK_FILTER_CALIBRATION_CONTROL 8'h0F

// fault_flag_control fields
`define PLCFE_BIT_THERMAL_EN 5
`define PLCFE_BIT_OVERCURRENT_EN 6
`define PLCFE_MASK_FAULT_FLAG_CONTROL 8'h60

// reset/status register fields
`define PLCFE_SOFT_RST_MSB 4
`define PLCFE_SOFT_RST_LSB 2
`define PLCFE_SOFT_RST_CODE 3'h5
`define PLCFE_BIT_THERMAL_FLAG 5
`define PLCFE_BIT_OVERCURRENT_FLAG 6

// serial frame layout and bit counts
`define PLCFE_FRAME_RW_BIT 15
`define PLCFE_FRAME_ADDR_MSB 13
`define PLCFE_FRAME_ADDR_LSB 8
`define PLCFE_FRAME_DATA_MSB 7
`define PLCFE_HDR_RW_BIT 7
`define PLCFE_HDR_ADDR_MSB 5
`define PLCFE_HDR_LAST 5'h07
`define PLCFE_HDR_BITS 5'h08
`define PLCFE_FRAME_BITS 5'h10
`define PLCFE_FRAME_OVERRUN 5'h11
`define PLCFE_SYNC_RST 3'h2

`endif

// file: plcfe_enable_control_regs.sv
// Function
// - second enable bit 0 powers the zero-crossing detector
// - second enable bit 1 switches reference block A
// - second enable bit 2 switches reference block B
// - second enable bit 3 drives amp output low impedance, else high impedance
// - second enable register at 0x03 resets to 0x00, bits 7:4 read zero
// - filter control bit 0 selects transmit calibration mode
// - filter control bit 1 selects receive calibration mode
// - filter control bit 2 selects transmit gain-stage calibration mode
// - filter control bit 3 selects band A response or shared B/C/D response
// - filter control bit 6 reads transmit readiness, read only
// - filter control bit 7 reports the receive block status
// - filter control register at 0x04 resets to 0x00, bits 5:4 reserved
// - fault control bit 5 allows the thermal-overload flag
// - fault control bit 6 allows the output-overcurrent flag
// - fault control register at 0x05 defaults to 0x01, low bits reserved
// - frame is direction bit, one unused bit, six address bits, eight data bits, rising-edge sampling
// - soft reset code 101 restores enable and control registers to defaults
// - fault flags latch until software writes zero to them
`timescale 1ns/1ps
`default_nettype none
`include "plcfe_consts.svh"

module plcfe_enable_control_regs (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic tx_ready_in,
    input wire logic rx_ready_in,
    input wire logic thermal_event_in,
    input wire logic overcurrent_event_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic zero_cross_enable_out,
    output logic reference_a_enable_out,
    output logic reference_b_enable_out,
    output logic amp_output_stage_enable_out,
    output logic transmit_calibration_out,
    output logic receive_calibration_out,
    output logic transmit_gain_stage_calibration_out,
    output logic filter_band_select_out,
    output logic thermal_flag_out,
    output logic overcurrent_flag_out
);
    plcfe_pkg::plcfe_byte_t block_enables_second;
    plcfe_pkg::plcfe_byte_t filter_calibration_control;
    plcfe_pkg::plcfe_byte_t fault_flag_control;
    plcfe_pkg::plcfe_byte_t rd_data;
    plcfe_pkg::plcfe_byte_t wr_data;
    plcfe_pkg::plcfe_addr_t hdr_addr;
    plcfe_pkg::plcfe_addr_t wr_addr;
    logic hdr_done, wr_strobe;
    logic wr_enables, wr_filter, wr_fault, wr_status, soft_reset;
    logic [3:0] status_raw;
    logic [3:0] status_sync;
    logic tx_ready_s, rx_ready_s, thermal_s, overcurrent_s;
    logic thermal_set, overcurrent_set, thermal_clr, overcurrent_clr;

    plcfe_spi_frame u_frame (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .sclk_in(sclk_in),
        .cs_n_in(cs_n_in),
        .mosi_in(mosi_in),
        .rd_data_in(rd_data),
        .miso_out(miso_out),
        .miso_oe_out(miso_oe_out),
        .hdr_done_out(hdr_done),
        .hdr_addr_out(hdr_addr),
        .wr_strobe_out(wr_strobe),
        .wr_addr_out(wr_addr),
        .wr_data_out(wr_data)
    );

    // analog status levels are asynchronous to clk_in
    assign status_raw = {overcurrent_event_in, thermal_event_in, rx_ready_in, tx_ready_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_status_sync
            logic stage_a;
            logic stage_b;
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    stage_a <= 1'h0;
                    stage_b <= 1'h0;
                end else begin
                    stage_a <= status_raw[gi];
                    stage_b <= stage_a;
                end
            end
            assign status_sync[gi] = stage_b;
        end
    endgenerate

    assign tx_ready_s = status_sync[0];
    assign rx_ready_s = status_sync[1];
    assign thermal_s = status_sync[2];
    assign overcurrent_s = status_sync[3];

    always_comb begin
        wr_enables = 1'h0;
        wr_filter = 1'h0;
        wr_fault = 1'h0;
        wr_status = 1'h0;
        if (wr_strobe && wr_addr == `PLCFE_ADDR_BLOCK_ENABLES_SECOND) begin
            wr_enables = 1'h1;
        end else if (wr_strobe && wr_addr == `PLCFE_ADDR_FILTER_CALIBRATION_CONTROL) begin
            wr_filter = 1'h1;
        end else if (wr_strobe && wr_addr == `PLCFE_ADDR_FAULT_FLAG_CONTROL) begin
            wr_fault = 1'h1;
        end else if (wr_strobe && wr_addr == `PLCFE_ADDR_RESET_STATUS) begin
            wr_status = 1'h1;
        end
    end

    assign soft_reset = wr_status
        && wr_data[`PLCFE_SOFT_RST_MSB:`PLCFE_SOFT_RST_LSB] == `PLCFE_SOFT_RST_CODE;

    // masks keep reserved bits at their default whatever the host writes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            block_enables_second <= `PLCFE_RST_BLOCK_ENABLES_SECOND;
        end else if (soft_reset) begin
            block_enables_second <= `PLCFE_RST_BLOCK_ENABLES_SECOND;
        end else if (wr_enables) begin
            block_enables_second <= wr_data & `PLCFE_MASK_BLOCK_ENABLES_SECOND;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            filter_calibration_control <= `PLCFE_RST_FILTER_CALIBRATION_CONTROL;
        end else if (soft_reset) begin
            filter_calibration_control <= `PLCFE_RST_FILTER_CALIBRATION_CONTROL;
        end else if (wr_filter) begin
            filter_calibration_control <= wr_data & `PLCFE_MASK_FILTER_CALIBRATION_CONTROL;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_flag_control <= `PLCFE_RST_FAULT_FLAG_CONTROL;
        end else if (soft_reset) begin
            fault_flag_control <= `PLCFE_RST_FAULT_FLAG_CONTROL;
        end else if (wr_fault) begin
            fault_flag_control <= (wr_data & `PLCFE_MASK_FAULT_FLAG_CONTROL)
                | (`PLCFE_RST_FAULT_FLAG_CONTROL & ~`PLCFE_MASK_FAULT_FLAG_CONTROL);
        end
    end

    // outputs are plain register bits, so they move only on a committed write
    assign zero_cross_enable_out = block_enables_second[`PLCFE_BIT_ZERO_CROSS];
    assign reference_a_enable_out = block_enables_second[`PLCFE_BIT_REFERENCE_A];
    assign reference_b_enable_out = block_enables_second[`PLCFE_BIT_REFERENCE_B];
    assign amp_output_stage_enable_out = block_enables_second[`PLCFE_BIT_AMP_OUTPUT];
    assign transmit_calibration_out = filter_calibration_control[`PLCFE_BIT_TX_CAL];
    assign receive_calibration_out = filter_calibration_control[`PLCFE_BIT_RX_CAL];
    assign transmit_gain_stage_calibration_out = filter_calibration_control[`PLCFE_BIT_TX_GAIN_CAL];
    assign filter_band_select_out = filter_calibration_control[`PLCFE_BIT_BAND];

    // a fault arriving in the clearing cycle wins over the clear
    assign thermal_set = thermal_s && fault_flag_control[`PLCFE_BIT_THERMAL_EN];
    assign overcurrent_set = overcurrent_s && fault_flag_control[`PLCFE_BIT_OVERCURRENT_EN];
    assign thermal_clr = wr_status && !wr_data[`PLCFE_BIT_THERMAL_FLAG];
    assign overcurrent_clr = wr_status && !wr_data[`PLCFE_BIT_OVERCURRENT_FLAG];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            thermal_flag_out <= 1'h0;
            overcurrent_flag_out <= 1'h0;
        end else begin
            thermal_flag_out <= thermal_set || (thermal_flag_out && !thermal_clr);
            overcurrent_flag_out <= overcurrent_set || (overcurrent_flag_out && !overcurrent_clr);
        end
    end

    // read data is chosen from the header address; unmapped addresses read zero
    always_comb begin
        rd_data = 8'h00;
        if (hdr_addr == `PLCFE_ADDR_BLOCK_ENABLES_SECOND) begin
            rd_data = block_enables_second;
        end else if (hdr_addr == `PLCFE_ADDR_FILTER_CALIBRATION_CONTROL) begin
            rd_data = filter_calibration_control;
            rd_data[`PLCFE_BIT_TX_READY] = tx_ready_s;
            rd_data[`PLCFE_BIT_RX_READY] = rx_ready_s;
        end else if (hdr_addr == `PLCFE_ADDR_FAULT_FLAG_CONTROL) begin
            rd_data = fault_flag_control;
        end else if (hdr_addr == `PLCFE_ADDR_RESET_STATUS) begin
            rd_data[`PLCFE_BIT_THERMAL_FLAG] = thermal_flag_out;
            rd_data[`PLCFE_BIT_OVERCURRENT_FLAG] = overcurrent_flag_out;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_zero_cross_write: assert property (wr_enables && !soft_reset |=>
        zero_cross_enable_out == $past(wr_data[0])) else $error("zero-cross enable not written");
    a_ref_a_write: assert property (wr_enables && !soft_reset |=>
        reference_a_enable_out == $past(wr_data[1])) else $error("reference A enable not written");
    a_ref_b_write: assert property (wr_enables && !soft_reset |=>
        reference_b_enable_out == $past(wr_data[2])) else $error("reference B enable not written");
    a_amp_stage_write: assert property (wr_enables && !soft_reset |=>
        amp_output_stage_enable_out == $past(wr_data[3])) else $error("amp stage enable not written");
    a_enables_reserved: assert property (hdr_addr == `PLCFE_ADDR_BLOCK_ENABLES_SECOND |->
        rd_data[7:4] == 4'h0) else $error("reserved enable bits read nonzero");
    a_cal_modes_write: assert property (wr_filter && !soft_reset |=>
        {transmit_gain_stage_calibration_out, receive_calibration_out, transmit_calibration_out}
        == $past(wr_data[2:0])) else $error("calibration mode not written");
    a_rx_cal_hold: assert property (!wr_filter && !soft_reset |=>
        $stable(receive_calibration_out)) else $error("receive calibration changed without write");
    a_tx_gain_hold: assert property (!wr_filter && !soft_reset |=>
        $stable(transmit_gain_stage_calibration_out)) else $error("gain calibration changed without write");
    a_band_write: assert property (wr_filter && !soft_reset |=>
        filter_band_select_out == $past(wr_data[3])) else $error("band select not written");
    a_tx_ready_read: assert property (hdr_addr == `PLCFE_ADDR_FILTER_CALIBRATION_CONTROL |->
        rd_data[6] == $past(tx_ready_in, 2)) else $error("tx ready bit wrong");
    a_rx_ready_read: assert property (hdr_addr == `PLCFE_ADDR_FILTER_CALIBRATION_CONTROL |->
        rd_data[7] == $past(rx_ready_in, 2)) else $error("rx ready bit wrong");
    a_filter_reserved: assert property (hdr_addr == `PLCFE_ADDR_FILTER_CALIBRATION_CONTROL |->
        rd_data[5:4] == 2'h0) else $error("reserved filter bits nonzero");
    a_thermal_gate: assert property (!fault_flag_control[5] && !thermal_flag_out |=> !thermal_flag_out)
        else $error("thermal flag set while disabled");
    a_overcur_gate: assert property (!fault_flag_control[6] && !overcurrent_flag_out |=>
        !overcurrent_flag_out) else $error("overcurrent flag set while disabled");
    a_fault_reserved: assert property (fault_flag_control[4:0] == 5'h01 && !fault_flag_control[7])
        else $error("fault control reserved bits wrong");
    a_soft_reset: assert property (soft_reset |=> block_enables_second == 8'h00
        && filter_calibration_control == 8'h00 && fault_flag_control == 8'h01)
        else $error("soft reset missed a register");
    a_flag_latched: assert property (thermal_flag_out && !thermal_clr |=> thermal_flag_out)
        else $error("thermal flag dropped without clear");
    a_flag_cleared: assert property (overcurrent_flag_out && overcurrent_clr && !overcurrent_set
        |=> !overcurrent_flag_out) else $error("overcurrent flag not cleared");
    a_unmapped_zero: assert property (hdr_addr != `PLCFE_ADDR_BLOCK_ENABLES_SECOND
        && hdr_addr != `PLCFE_ADDR_FILTER_CALIBRATION_CONTROL && hdr_addr != `PLCFE_ADDR_FAULT_FLAG_CONTROL
        && hdr_addr != `PLCFE_ADDR_RESET_STATUS |-> rd_data == 8'h00) else $error("unmapped address read nonzero");
    a_commit_only: assert property (!$stable(block_enables_second) |-> $past(wr_strobe))
        else $error("enable register changed without committed frame");
endmodule

`default_nettype wire

// file: plcfe_enable_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module plcfe_enable_control_regs_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic tx_rdy = 1'b1;
    logic rx_rdy = 1'b0;
    logic therm = 1'b0;
    logic ovc = 1'b0;
    logic [7:0] rv;
    wire logic sclk, cs_n, mosi, miso, miso_oe;
    wire logic [9:0] outs;
    int mismatches = 0;
    int checks = 0;

    initial forever #10 clk_in = ~clk_in;

    plcfe_host_model u_plcfe_host_model (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk),
        .cs_n_out(cs_n), .mosi_out(mosi));

    plcfe_enable_control_regs u_plcfe_enable_control_regs (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .tx_ready_in(tx_rdy), .rx_ready_in(rx_rdy),
        .thermal_event_in(therm), .overcurrent_event_in(ovc), .miso_out(miso), .miso_oe_out(miso_oe),
        .zero_cross_enable_out(outs[0]), .reference_a_enable_out(outs[1]),
        .reference_b_enable_out(outs[2]), .amp_output_stage_enable_out(outs[3]),
        .transmit_calibration_out(outs[4]), .receive_calibration_out(outs[5]),
        .transmit_gain_stage_calibration_out(outs[6]), .filter_band_select_out(outs[7]),
        .thermal_flag_out(outs[8]), .overcurrent_flag_out(outs[9]));

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // pins are read at the falling edge, where every register output has settled
    task automatic chk_pins(input logic [9:0] exp);
        @(negedge clk_in);
        chk(outs, exp);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        u_plcfe_host_model.xfer(plcfe_pkg::PLCFE_DIR_WRITE, a, d, x);
        repeat (8) @(posedge clk_in);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] x;
        u_plcfe_host_model.xfer(plcfe_pkg::PLCFE_DIR_READ, a, 8'h00, x);
        @(negedge clk_in);
        // output enable still stands here: the released select is not yet through the synchroniser
        chk({1'b0, miso_oe, x}, {2'h1, e});
    endtask

    // event levels are held a few cycles so the synchronizers catch them
    task automatic ev(input logic t, input logic o);
        @(posedge clk_in);
        therm <= t;
        ovc <= o;
        repeat (4) @(posedge clk_in);
        therm <= 1'b0;
        ovc <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_in);
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk_pins(10'h000);
        rd(6'h03, 8'h00);
        rd(6'h04, 8'h40);
        rd(6'h05, 8'h01);
        rd(6'h07, 8'h00);
        $display("test reset values done");
        u_plcfe_host_model.xfer(plcfe_pkg::PLCFE_DIR_WRITE, 6'h03, 8'hFF, rv);
        chk_pins(10'h000);
        chk({1'b0, miso_oe, rv}, 10'h000);
        repeat (8) @(posedge clk_in);
        chk_pins(10'h00F);
        rd(6'h03, 8'h0F);
        wr(6'h03, 8'h0A);
        chk_pins(10'h00A);
        wr(6'h04, 8'hFF);
        rx_rdy <= 1'b1;
        chk_pins(10'h0FA);
        rd(6'h04, 8'hCF);
        wr(6'h04, 8'h05);
        tx_rdy <= 1'b0;
        chk_pins(10'h05A);
        rd(6'h04, 8'h85);
        $display("test enables done");
        wr(6'h05, 8'hFF);
        rd(6'h05, 8'h61);
        ev(1'b1, 1'b0);
        chk_pins(10'h15A);
        ev(1'b0, 1'b1);
        chk_pins(10'h35A);
        rd(6'h09, 8'h60);
        wr(6'h09, 8'h20);
        chk_pins(10'h15A);
        wr(6'h09, 8'h00);
        chk_pins(10'h05A);
        wr(6'h05, 8'h01);
        ev(1'b1, 1'b1);
        chk_pins(10'h05A);
        $display("test fault flags done");
        wr(6'h05, 8'hFF);
        ev(1'b1, 1'b1);
        wr(6'h09, 8'h74);
        chk_pins(10'h300);
        rd(6'h03, 8'h00);
        rd(6'h04, 8'h80);
        rd(6'h05, 8'h01);
        $display("test soft reset done");
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk_pins(10'h000);
        rd(6'h05, 8'h01);
        $display("test hard reset done");
        close_out();
    end
endmodule

`default_nettype wire

// file: plcfe_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module plcfe_host_model (
    input wire logic clk_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // one frame; the gap sits at the front so the caller sees the edge of the release
    task automatic xfer(input plcfe_pkg::plcfe_dir_e dir, input plcfe_pkg::plcfe_addr_t addr,
                        input plcfe_pkg::plcfe_byte_t wdata, output plcfe_pkg::plcfe_byte_t rdata);
        logic [15:0] frame;
        frame = {dir, 1'b0, addr, wdata};
        rdata = 8'h00;
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_in);
            sclk_out <= 1'b0;
            mosi_out <= frame[i];
            repeat (5) @(posedge clk_in);
            sclk_out <= 1'b1;
            if (i < 8) rdata[i] = miso_in;
            repeat (2) @(posedge clk_in);
        end
        @(posedge clk_in);
        sclk_out <= 1'b0;
        repeat (2) @(posedge clk_in);
        cs_n_out <= 1'b1;
        // no pull on the data line, so it must not keep the last bit
        mosi_out <= ~frame[0];
    endtask
endmodule

`default_nettype wire

// file: plcfe_pkg.sv
`default_nettype none
package plcfe_pkg;
    typedef logic [7:0] plcfe_byte_t;
    typedef logic [5:0] plcfe_addr_t;
    typedef enum logic {
        PLCFE_DIR_WRITE = 1'h0,
        PLCFE_DIR_READ = 1'h1
    } plcfe_dir_e;
endpackage

`default_nettype wire

// file: plcfe_spi_frame.sv
`timescale 1ns/1ps
`default_nettype none
`include "plcfe_consts.svh"

module plcfe_spi_frame (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire plcfe_pkg::plcfe_byte_t rd_data_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic hdr_done_out,
    output var plcfe_pkg::plcfe_addr_t hdr_addr_out,
    output logic wr_strobe_out,
    output var plcfe_pkg::plcfe_addr_t wr_addr_out,
    output var plcfe_pkg::plcfe_byte_t wr_data_out
);
    logic [2:0] pin_raw;
    logic [2:0] pin_sync;
    // a constant, so the asynchronous reset branch loads only constants
    localparam logic [2:0] sync_rst = `PLCFE_SYNC_RST;
    logic sclk_s, cs_n_s, mosi_s, sclk_d, cs_n_d;
    logic sclk_rise, sclk_fall, cs_rise;
    logic [4:0] bit_count;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic frame_read;
    logic in_data_phase;

    assign pin_raw = {mosi_in, cs_n_in, sclk_in};

    // pins come from the host clock domain: two flops before any use
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            logic stage_a;
            logic stage_b;
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    stage_a <= sync_rst[gi];
                    stage_b <= sync_rst[gi];
                end else begin
                    stage_a <= pin_raw[gi];
                    stage_b <= stage_a;
                end
            end
            assign pin_sync[gi] = stage_b;
        end
    endgenerate

    assign sclk_s = pin_sync[0];
    assign cs_n_s = pin_sync[1];
    assign mosi_s = pin_sync[2];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_d <= 1'h0;
            cs_n_d <= 1'h1;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;
    assign cs_rise = cs_n_s & ~cs_n_d;
    assign in_data_phase = (bit_count >= `PLCFE_HDR_BITS) && (bit_count < `PLCFE_FRAME_BITS);

    // count saturates past a full frame so long frames are never committed
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_count <= 5'h00;
        end else if (cs_n_s) begin
            bit_count <= 5'h00;
        end else if (sclk_rise && bit_count != `PLCFE_FRAME_OVERRUN) begin
            bit_count <= bit_count + 5'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_in <= 16'h0000;
        end else if (!cs_n_s && sclk_rise) begin
            shift_in <= {shift_in[14:0], mosi_s};
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hdr_done_out <= 1'h0;
        end else begin
            hdr_done_out <= !cs_n_s && sclk_rise && bit_count == `PLCFE_HDR_LAST;
        end
    end

    assign hdr_addr_out = shift_in[`PLCFE_HDR_ADDR_MSB:0];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frame_read <= 1'h0;
        end else if (cs_n_s) begin
            frame_read <= 1'h0;
        end else if (hdr_done_out) begin
            frame_read <= shift_in[`PLCFE_HDR_RW_BIT] == plcfe_pkg::PLCFE_DIR_READ;
        end
    end

    assign miso_oe_out = frame_read;

    // read data is launched on falling edges so the host samples it on rising ones
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_out <= 8'h00;
            miso_out <= 1'h0;
        end else if (cs_n_s) begin
            miso_out <= 1'h0;
        end else if (hdr_done_out && shift_in[`PLCFE_HDR_RW_BIT]) begin
            shift_out <= rd_data_in;
        end else if (sclk_fall && frame_read && in_data_phase) begin
            miso_out <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'h0};
        end
    end

    // a write lands only once chip select is released after exactly sixteen bits
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_strobe_out <= 1'h0;
            wr_addr_out <= 6'h00;
            wr_data_out <= 8'h00;
        end else begin
            wr_strobe_out <= cs_rise && bit_count == `PLCFE_FRAME_BITS
                && shift_in[`PLCFE_FRAME_RW_BIT] == plcfe_pkg::PLCFE_DIR_WRITE;
            if (cs_rise) begin
                wr_addr_out <= shift_in[`PLCFE_FRAME_ADDR_MSB:`PLCFE_FRAME_ADDR_LSB];
                wr_data_out <= shift_in[`PLCFE_FRAME_DATA_MSB:0];
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_first_fall;
        sclk_fall && frame_read && bit_count == `PLCFE_HDR_BITS && !cs_n_s;
    endsequence
    sequence s_msb_out;
        miso_out == $past(shift_out[7]);
    endsequence
    property p_first_out;
        s_first_fall |=> s_msb_out;
    endproperty
    a_read_first_bit: assert property (p_first_out) else $error("read msb not launched");
    a_frame_length: assert property (wr_strobe_out |-> $past(bit_count) == `PLCFE_FRAME_BITS
        && $past(cs_rise)) else $error("write committed from a bad frame");
    a_read_no_commit: assert property (wr_strobe_out |-> !$past(shift_in[15]))
        else $error("read frame committed as a write");
    a_commit_cs_high: assert property (wr_strobe_out |-> cs_n_s)
        else $error("write committed while selected");
endmodule

`default_nettype wire
